/* File: core/input_clock_select.sv */
// Reference clock selection: decodes straps and supply level into a PLL setting.
// Assumes strap and supply-detect inputs are asynchronous pins; one 10 MHz clock.
`timescale 1ns/100ps

module input_clock_select
   import clk_sel_pkg::*;
#(
   parameter logic [1:0] VARIANT = VAR_FULL
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       clk_en_in,
   // Strap and supply sense pins
   input  wire logic [1:0] ref_freq_select_in,
   input  wire logic       osc_io_supply_hi_in,
   input  wire logic       core_power_on_in,
   // Oscillator pin control
   output logic            osc_output_pin_oe_out,
   output logic            pins_tristate_out,
   // PLL setting
   output pll_cfg_t        pll_cfg_out,
   output logic            cfg_valid_out,
   output logic            cfg_error_out
);

   // ************************************************************
   // Parameter check
   // ************************************************************
   if (VARIANT != VAR_FULL && VARIANT != VAR_REDUCED
       && VARIANT != VAR_LITE) begin : g_bad_variant
      $error("input_clock_select: unsupported VARIANT");
   end

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   // Straps must settle before reset release; the bits cross unaligned
   logic [1:0] sel_s1_r, sel_s2_r;
   logic       sup_s1_r, sup_s2_r;
   logic       pwr_s1_r, pwr_s2_r;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sel_s1_r <= 2'h0;
         sel_s2_r <= 2'h0;
         sup_s1_r <= 1'h0;
         sup_s2_r <= 1'h0;
         pwr_s1_r <= 1'h0;
         pwr_s2_r <= 1'h0;
      end else if (clk_en_in) begin
         sel_s1_r <= ref_freq_select_in;
         sel_s2_r <= sel_s1_r;
         sup_s1_r <= osc_io_supply_hi_in;
         sup_s2_r <= sup_s1_r;
         pwr_s1_r <= core_power_on_in;
         pwr_s2_r <= pwr_s1_r;
      end
   end

   // ************************************************************
   // Decode
   // ************************************************************
   pll_cfg_t cfg_nxt;
   logic     err_nxt;

   always_comb begin
      cfg_nxt           = '0;
      cfg_nxt.ext_clock = !sup_s2_r;
      cfg_nxt.crystal   = sup_s2_r;
      err_nxt           = 1'b0;
      case (VARIANT)
         VAR_FULL: begin
            case (sel_s2_r)
               SEL_19M2: begin
                  cfg_nxt.ref_khz = F_19M2_KHZ;
                  cfg_nxt.mul     = MUL_19M2;
                  cfg_nxt.div     = DIV_19M2;
               end
               SEL_24M: begin
                  cfg_nxt.ref_khz = F_24M_KHZ;
                  cfg_nxt.mul     = MUL_24M;
                  cfg_nxt.div     = DIV_24M;
               end
               SEL_48M: begin
                  cfg_nxt.ref_khz = F_48M_KHZ;
                  cfg_nxt.mul     = MUL_48M;
                  cfg_nxt.div     = DIV_48M;
                  err_nxt         = sup_s2_r;
               end
               default: begin
                  cfg_nxt.ref_khz = F_26M_KHZ;
                  cfg_nxt.mul     = MUL_26M;
                  cfg_nxt.div     = DIV_26M;
               end
            endcase
         end
         VAR_REDUCED: begin
            err_nxt = sup_s2_r;
            if (sel_s2_r[0]) begin
               cfg_nxt.ref_khz = F_26M_KHZ;
               cfg_nxt.mul     = MUL_26M;
               cfg_nxt.div     = DIV_26M;
            end else begin
               cfg_nxt.ref_khz = F_19M2_KHZ;
               cfg_nxt.mul     = MUL_19M2;
               cfg_nxt.div     = DIV_19M2;
            end
         end
         default: begin
            cfg_nxt.ref_khz = F_26M_KHZ;
            cfg_nxt.mul     = MUL_26M;
            cfg_nxt.div     = DIV_26M;
         end
      endcase
   end

   // ************************************************************
   // Capture once after reset release
   // ************************************************************
   // Two enabled edges fill the synchroniser before the capture
   logic [1:0] fill_r;
   logic       cfg_valid_r;
   pll_cfg_t   cfg_r;
   logic       err_r;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fill_r      <= 2'h0;
         cfg_valid_r <= 1'b0;
         cfg_r       <= '0;
         err_r       <= 1'b0;
      end else if (clk_en_in) begin
         if (fill_r != SYNC_FILL_CNT) begin
            fill_r <= fill_r + 2'h1;
         end else if (!cfg_valid_r) begin
            cfg_r       <= cfg_nxt;
            err_r       <= err_nxt;
            cfg_valid_r <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign pll_cfg_out   = cfg_r;
   assign cfg_valid_out = cfg_valid_r;
   assign cfg_error_out = err_r;
   // Crystal feedback drive only with a crystal; pin floats for a clock
   assign pins_tristate_out     = !pwr_s2_r;
   assign osc_output_pin_oe_out = pwr_s2_r && cfg_valid_r && cfg_r.crystal;

   // ************************************************************
   // Checks
   // ************************************************************
   // Capture is two steps: synchroniser full, then the decode lands
   sequence sync_full_s;
      clk_en_in && fill_r == SYNC_FILL_CNT && !cfg_valid_r;
   endsequence
   sequence decode_landed_s;
      cfg_valid_r && cfg_r == $past(cfg_nxt) && err_r == $past(err_nxt);
   endsequence

   capture_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
      sync_full_s |=> decode_landed_s)
      else $error("capture missed the synchronised decode");
   hold_cfg_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $past(cfg_valid_r) |-> $stable(cfg_r))
      else $error("setting changed after capture");
   stall_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !clk_en_in |=> $stable(fill_r) && $stable(cfg_valid_r) && $stable(cfg_r))
      else $error("state moved while clock enable low");
   // Two enabled edges after the core power-on pin drops, every drive is off
   core_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $past(clk_en_in) && $past(clk_en_in, 2) && !$past(core_power_on_in, 2)
      |-> pins_tristate_out && !osc_output_pin_oe_out)
      else $error("pins driven with core off");
   ext_clk_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_valid_r |-> cfg_r.ext_clock != cfg_r.crystal)
      else $error("source type inconsistent");
   no_xtal48_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_valid_r && cfg_r.ref_khz == F_48M_KHZ && cfg_r.crystal |-> err_r)
      else $error("crystal at 48 MHz not flagged");
   // Every decoded reference must land on the same core rate
   core_rate_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_valid_r |-> 32'(cfg_r.ref_khz) * 32'(cfg_r.mul)
                      == 32'(F_48M_KHZ) * 32'(MUL_48M) * 32'(cfg_r.div))
      else $error("core rate depends on reference");
   lite_26_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_valid_r && VARIANT == VAR_LITE |-> cfg_r.ref_khz == F_26M_KHZ)
      else $error("lite variant not at 26 MHz");
   red_clk_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_valid_r && VARIANT == VAR_REDUCED |-> err_r == cfg_r.crystal)
      else $error("reduced variant crystal not flagged");
   red_dec_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(cfg_valid_r) && VARIANT == VAR_REDUCED
      |-> cfg_r.ref_khz == ($past(sel_s2_r[0]) ? F_26M_KHZ : F_19M2_KHZ))
      else $error("reduced variant select not decoded");
   capture_time_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(cfg_valid_r) |-> $past(fill_r) == SYNC_FILL_CNT)
      else $error("capture before synchroniser filled");
   full_dec_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(cfg_valid_r) && VARIANT == VAR_FULL && $past(sel_s2_r) == SEL_24M
      |-> cfg_r.ref_khz == F_24M_KHZ)
      else $error("select 01 not decoded as 24 MHz");
   sel48_dec_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(cfg_valid_r) && VARIANT == VAR_FULL && $past(sel_s2_r) == SEL_48M
      |-> cfg_r.ref_khz == F_48M_KHZ)
      else $error("select 10 not decoded as 48 MHz");

endmodule

/* File: core/clk_sel_pkg.sv */
// Constants and carrier types for reference clock selection.
// Assumes a single 10 MHz system clock and an asynchronous active-high reset.
package clk_sel_pkg;

   // ************************************************************
   // Variants and select codes
   // ************************************************************
   localparam logic [1:0] VAR_FULL    = 2'h0;
   localparam logic [1:0] VAR_REDUCED = 2'h1;
   localparam logic [1:0] VAR_LITE    = 2'h2;

   localparam logic [1:0] SEL_19M2    = 2'h0;
   localparam logic [1:0] SEL_24M     = 2'h1;
   localparam logic [1:0] SEL_48M     = 2'h2;
   localparam logic [1:0] SEL_26M     = 2'h3;

   // Enabled edges that fill the two-flop synchroniser before capture
   localparam logic [1:0] SYNC_FILL_CNT = 2'h2;

   // ************************************************************
   // Reference frequencies (kHz)
   // ************************************************************
   localparam logic [15:0] F_19M2_KHZ  = 16'h4B00;
   localparam logic [15:0] F_24M_KHZ   = 16'h5DC0;
   localparam logic [15:0] F_48M_KHZ   = 16'hBB80;
   localparam logic [15:0] F_26M_KHZ   = 16'h6590;

   // PLL factors as multiply over divide onto a common core rate
   localparam logic [7:0] MUL_19M2 = 8'h19;
   localparam logic [7:0] DIV_19M2 = 8'h01;
   localparam logic [7:0] MUL_24M  = 8'h14;
   localparam logic [7:0] DIV_24M  = 8'h01;
   localparam logic [7:0] MUL_48M  = 8'h0A;
   localparam logic [7:0] DIV_48M  = 8'h01;
   localparam logic [7:0] MUL_26M  = 8'hF0;
   localparam logic [7:0] DIV_26M  = 8'h0D;

   typedef struct packed {
      logic [15:0] ref_khz;
      logic [7:0]  mul;
      logic [7:0]  div;
      logic        ext_clock;
      logic        crystal;
   } pll_cfg_t;

endpackage

/* File: bench/osc_source_model.sv */
// Far-side model: crystal or external clock source on the oscillator pins.
// Assumes the bench picks the source kind and when the source must park.
`timescale 1ns/100ps
module osc_source_model (
   // Clock
   input  wire logic clk_in,
   // Source setup
   input  wire logic crystal_in,
   input  wire logic park_in,
   // Pins
   output logic      osc_io_supply_hi_out,
   output logic      osc_input_pin_out
);
   // ***********************************************
   // Supply level tells crystal from clock
   // ***********************************************
   assign osc_io_supply_hi_out = crystal_in;
   logic wave_r = 1'b0;
   assign osc_input_pin_out = wave_r;
   // Parked low, not toggling, to save current
   always @(posedge clk_in) begin
      if (park_in) wave_r <= 1'b0;
      else wave_r <= ~wave_r;
   end
endmodule

/* File: bench/input_clock_select_tb_top.sv */
// Testbench: all three variants side by side, fed the same straps and supply.
// Assumes the design package and the oscillator source model are compiled first.
`timescale 1ns/100ps
module input_clock_select_tb_top;
   import clk_sel_pkg::*;
   // ***********************************************
   // Signals and instances
   // ***********************************************
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       clk_en_in = 1'b1;
   logic [1:0] ref_freq_select = 2'h0;
   logic       xtal_mode = 1'b0;
   logic       park = 1'b0;
   logic       power_on = 1'b1;
   logic       supply_hi;
   logic       osc_wave;
   pll_cfg_t   cfg [3];
   logic [2:0] valid, err, oe, tri_s;
   int         n_errors = 0;
   int         tests_run = 0;
   localparam logic [15:0] KHZ_TAB [4] = '{F_19M2_KHZ, F_24M_KHZ, F_48M_KHZ, F_26M_KHZ};
   always #50 clk_in = ~clk_in;
   osc_source_model partner (.clk_in(clk_in), .crystal_in(xtal_mode), .park_in(park),
      .osc_io_supply_hi_out(supply_hi), .osc_input_pin_out(osc_wave));
   for (genvar v = 0; v < 3; v++) begin : g_var
      input_clock_select #(.VARIANT(2'(v))) uut (.clk_in(clk_in), .rst_in(rst_in),
         .clk_en_in(clk_en_in), .ref_freq_select_in(ref_freq_select),
         .osc_io_supply_hi_in(supply_hi), .core_power_on_in(power_on),
         .osc_output_pin_oe_out(oe[v]), .pins_tristate_out(tri_s[v]),
         .pll_cfg_out(cfg[v]), .cfg_valid_out(valid[v]), .cfg_error_out(err[v]));
   end
   // ***********************************************
   // Shared tasks
   // ***********************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic restart(input logic [1:0] sel, input logic xtal);
      @(negedge clk_in);
      ref_freq_select = sel;
      xtal_mode = xtal;
      rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic check_decode();
      logic [1:0] k;
      for (int s = 0; s < 4; s++) begin
         for (int x = 0; x < 2; x++) begin
            restart(2'(s), x[0]);
            for (int v = 0; v < 3; v++) begin
               k = (v == 0) ? 2'(s) : ((v == 1) ? {2{s[0]}} : 2'h3);
               chk("valid", 1, valid[v]);
               chk("ref_khz", KHZ_TAB[k], cfg[v].ref_khz);
               chk("core_khz", 480000, 32'(cfg[v].ref_khz) * cfg[v].mul / cfg[v].div);
               chk("crystal", x, cfg[v].crystal);
               chk("ext_clock", x == 0, cfg[v].ext_clock);
               chk("error", (v == 0 && s == 2 && x == 1) || (v == 1 && x == 1), err[v]);
               chk("oe", x, oe[v]);
            end
         end
      end
   endtask
   // Late strap changes must not leak into the held setting
   task automatic check_hold();
      restart(2'h0, 1'b0);
      ref_freq_select = 2'h3;
      xtal_mode = 1'b1;
      repeat (5) @(negedge clk_in);
      chk("held ref_khz", F_19M2_KHZ, cfg[0].ref_khz);
      chk("held crystal", 0, cfg[0].crystal);
   endtask
   task automatic check_power();
      restart(2'h0, 1'b1);
      power_on = 1'b0;
      park = 1'b1;
      repeat (3) @(negedge clk_in);
      chk("tristate off", 3'h7, tri_s);
      chk("oe off", 0, oe[0]);
      chk("oe off all", 3'h0, oe);
      chk("parked pin", 0, osc_wave);
      power_on = 1'b1;
      park = 1'b0;
      repeat (3) @(negedge clk_in);
      chk("tristate on", 3'h0, tri_s);
   endtask
   task automatic check_stall();
      rst_in = 1'b1;
      clk_en_in = 1'b0;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (5) @(negedge clk_in);
      chk("stalled valid", 0, valid[0]);
      clk_en_in = 1'b1;
      repeat (2) @(negedge clk_in);
      chk("early valid", 0, valid[0]);
      repeat (2) @(negedge clk_in);
      chk("late valid", 1, valid[0]);
   endtask
   task automatic give_verdict();
      $display("checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ***********************************************
   // Sequence and watchdog
   // ***********************************************
   initial begin
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      check_decode();
      check_hold();
      check_power();
      check_stall();
      give_verdict();
   end
   // Run needs about 100 cycles; far more means a hang
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule
